// [common/ccp_pkg.sv]
// Purpose: Shared constants and types for the capture clamp and output port control block.
// Assumes: One pixel clock drives both ends; register data is 8 bits wide.
// Notes:   Host register offsets are byte addresses of 32-bit Wishbone words.
package ccp_pkg;

  // ********************************
  // Device register offsets
  // ********************************
  localparam logic [7:0] CLAMP_START_OFS  = 8'h08;
  localparam logic [7:0] CLAMP_LENGTH_OFS = 8'h09;
  localparam logic [7:0] GEN_CTRL_OFS     = 8'h0A;
  localparam logic [7:0] PHASE_OFS        = 8'h0B;
  localparam logic [7:0] CLK_GEN_OFS      = 8'h0C;
  localparam logic [7:0] OUT_CTRL_OFS     = 8'h0D;

  // ********************************
  // Field positions
  // ********************************
  localparam int DUAL_PORT_BIT     = 7;
  localparam int PARALLEL_BIT      = 6;
  localparam int SYNC_POL_BIT      = 5;
  localparam int HOLD_FREQUENCY_IN_POL_BIT     = 4;
  localparam int CLAMP_SRC_BIT     = 3;
  localparam int EXT_CLAMP_POL_BIT = 2;
  localparam int CLK_SRC_BIT       = 1;
  localparam int PHASE_LSB         = 3;
  localparam int OSC_RANGE_LSB     = 5;
  localparam int PUMP_LSB          = 2;
  localparam int SWAP_WR_BIT       = 4;
  localparam int SWAP_RD_BIT       = 7;
  localparam int REVISION_LSB      = 1;

  // ********************************
  // Reset values
  // ********************************
  localparam logic [7:0] CLAMP_START_RST  = 8'h80;
  localparam logic [7:0] CLAMP_LENGTH_RST = 8'h80;
  localparam logic [7:0] GEN_CTRL_RST     = 8'hF4;
  localparam logic [4:0] PHASE_RST        = 5'h10;
  localparam logic [1:0] OSC_RANGE_RST    = 2'h1;
  localparam logic [2:0] PUMP_RST         = 3'h1;
  localparam logic       SWAP_RST         = 1'b0;
  // Arbitrary value, chosen only to be recognisable on read-back.
  localparam logic [2:0] DIE_REVISION     = 3'h2;

  // ********************************
  // Host Wishbone offsets
  // ********************************
  localparam logic [3:0] HOST_CMD_OFS    = 4'h0;
  localparam logic [3:0] HOST_STATUS_OFS = 4'h4;
  localparam logic [3:0] HOST_PIXEL_OFS  = 4'h8;
  localparam int         CMD_ADDR_LSB    = 8;
  localparam int         CMD_WRITE_BIT   = 16;

  // ********************************
  // Clamp timer states
  // ********************************
  typedef enum logic [1:0]
  {
    CL_IDLE = 2'b00,
    CL_WAIT = 2'b01,
    CL_ON   = 2'b10
  } ccp_clamp_state_t;

endpackage

// [common/ccp_link_if.sv]
// Purpose: Link between the capture device and the downstream controller.
// Assumes: Both ends run on the same pixel clock.
// Notes:   Port B is three-state; its enable is low while the device drives it.
`timescale 1ns/10ps
interface ccp_link_if;
  logic       regSel;
  logic       regWe;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic [7:0] regRdData;
  logic       regAck;
  logic [7:0] portAData;
  logic [7:0] portBData;
  logic       portBOe_n;
  logic       dataClk;

  modport device
  (
    input  regSel, regWe, regAddr, regWrData,
    output regRdData, regAck, portAData, portBData, portBOe_n, dataClk
  );

  modport host
  (
    output regSel, regWe, regAddr, regWrData,
    input  regRdData, regAck, portAData, portBData, portBOe_n, dataClk
  );
endinterface

// [hw/ccp_device.sv]
// Purpose: Capture device end: clamp timer, sync and hold_frequency_in polarity, clock controls, pixel port steering.
// Assumes: Pins lineSyncIn, coastIn and clampIn are asynchronous; pixels arrive on clk with pixelStrobe.
// Notes:   One register access is answered per request, one cycle after it is seen.
//
// Our own choice: the Wishbone register port.
`timescale 1ns/10ps
module ccp_device
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Link to the controller
  ccp_link_if.device      link,
  // Analog-side pins
  input  wire logic       lineSyncIn,
  input  wire logic       coastIn,
  input  wire logic       clampIn,
  // Converter samples
  input  wire logic [7:0] pixelIn,
  input  wire logic       pixelStrobe,
  // Front-end controls
  output logic            clampActive,
  output logic            pllHold,
  output logic            pllSyncRef,
  output logic            clockSourceExt,
  output logic [4:0]      samplePhase,
  output logic [1:0]      oscRange,
  output logic [2:0]      pumpCurrent
);

  // ********************************
  // Registers
  // ********************************
  logic [7:0] clampStart_r;
  logic [7:0] clampLength_r;
  logic [7:0] genCtrl_r;
  logic [4:0] phase_r;
  logic [1:0] oscRange_r;
  logic [2:0] pump_r;
  logic       portSwap_r;
  logic [7:0] rdData_r;
  logic       ack_r;
  logic       regWrite;
  logic [7:0] rdMux;

  assign regWrite = link.regSel & link.regWe & ~ack_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      clampStart_r  <= ccp_pkg::CLAMP_START_RST;
      clampLength_r <= ccp_pkg::CLAMP_LENGTH_RST;
      genCtrl_r     <= ccp_pkg::GEN_CTRL_RST;
      phase_r       <= ccp_pkg::PHASE_RST;
      oscRange_r    <= ccp_pkg::OSC_RANGE_RST;
      pump_r        <= ccp_pkg::PUMP_RST;
      portSwap_r    <= ccp_pkg::SWAP_RST;
    end
    else if (regWrite)
    begin
      unique case (link.regAddr)
        ccp_pkg::CLAMP_START_OFS:  clampStart_r  <= link.regWrData;
        ccp_pkg::CLAMP_LENGTH_OFS: clampLength_r <= link.regWrData;
        ccp_pkg::GEN_CTRL_OFS:     genCtrl_r     <= {link.regWrData[7:1], 1'b0};
        ccp_pkg::PHASE_OFS:        phase_r       <= link.regWrData[ccp_pkg::PHASE_LSB +: 5];
        ccp_pkg::CLK_GEN_OFS:
        begin
          oscRange_r <= link.regWrData[ccp_pkg::OSC_RANGE_LSB +: 2];
          pump_r     <= link.regWrData[ccp_pkg::PUMP_LSB +: 3];
        end
        ccp_pkg::OUT_CTRL_OFS:     portSwap_r    <= link.regWrData[ccp_pkg::SWAP_WR_BIT];
        default:                   ;
      endcase
    end
  end

  always_comb
  begin
    rdMux = 8'h00;
    unique case (link.regAddr)
      ccp_pkg::CLAMP_START_OFS:  rdMux = clampStart_r;
      ccp_pkg::CLAMP_LENGTH_OFS: rdMux = clampLength_r;
      ccp_pkg::GEN_CTRL_OFS:     rdMux = genCtrl_r;
      ccp_pkg::PHASE_OFS:        rdMux[ccp_pkg::PHASE_LSB +: 5] = phase_r;
      ccp_pkg::CLK_GEN_OFS:      rdMux = {1'b0, oscRange_r, pump_r, 2'b00};
      ccp_pkg::OUT_CTRL_OFS:
      begin
        rdMux[ccp_pkg::SWAP_RD_BIT]          = portSwap_r;
        rdMux[ccp_pkg::REVISION_LSB +: 3]    = ccp_pkg::DIE_REVISION;
      end
      default:                   rdMux = 8'h00;
    endcase
  end

  // Every request is answered, an unmapped address reads as zero.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ack_r    <= 1'b0;
      rdData_r <= 8'h00;
    end
    else
    begin
      ack_r <= link.regSel & ~ack_r;
      if (link.regSel & ~ack_r)
      begin
        rdData_r <= rdMux;
      end
    end
  end

  assign link.regAck    = ack_r;
  assign link.regRdData = rdData_r;

  // ********************************
  // Pin synchronisers
  // ********************************
  // A level is accepted only when the second and third stages agree, which rejects single-cycle glitches.
  logic [2:0] pinRaw;
  logic [2:0] pinS1_r;
  logic [2:0] pinS2_r;
  logic [2:0] pinS3_r;
  logic [2:0] pinLvl_r;

  assign pinRaw = {clampIn, coastIn, lineSyncIn};

  for (genvar i = 0; i < 3; i++)
  begin : gSync
    always_ff @(posedge clk)
    begin
      if (!rst_n)
      begin
        pinS1_r[i]  <= 1'b0;
        pinS2_r[i]  <= 1'b0;
        pinS3_r[i]  <= 1'b0;
        pinLvl_r[i] <= 1'b0;
      end
      else
      begin
        pinS1_r[i] <= pinRaw[i];
        pinS2_r[i] <= pinS1_r[i];
        pinS3_r[i] <= pinS2_r[i];
        if (pinS2_r[i] == pinS3_r[i])
        begin
          pinLvl_r[i] <= pinS3_r[i];
        end
      end
    end
  end

  // ********************************
  // Sync, hold_frequency_in and clock controls
  // ********************************
  logic syncActive;
  logic syncActivePrev_r;
  logic leadEdge;
  logic trailEdge;
  logic coastActive;
  logic extClampActive;

  assign syncActive     = genCtrl_r[ccp_pkg::SYNC_POL_BIT] ? pinLvl_r[0] : ~pinLvl_r[0];
  assign leadEdge       = syncActive & ~syncActivePrev_r;
  assign trailEdge      = ~syncActive & syncActivePrev_r;
  assign coastActive    = genCtrl_r[ccp_pkg::HOLD_FREQUENCY_IN_POL_BIT] ? pinLvl_r[1] : ~pinLvl_r[1];
  assign extClampActive = genCtrl_r[ccp_pkg::EXT_CLAMP_POL_BIT] ? pinLvl_r[2] : ~pinLvl_r[2];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      syncActivePrev_r <= 1'b0;
      pllHold          <= 1'b0;
      pllSyncRef       <= 1'b0;
      clockSourceExt   <= 1'b0;
      samplePhase      <= ccp_pkg::PHASE_RST;
      oscRange         <= ccp_pkg::OSC_RANGE_RST;
      pumpCurrent      <= ccp_pkg::PUMP_RST;
    end
    else
    begin
      syncActivePrev_r <= syncActive;
      pllHold          <= coastActive;
      pllSyncRef       <= syncActive & ~coastActive;
      clockSourceExt   <= genCtrl_r[ccp_pkg::CLK_SRC_BIT];
      samplePhase      <= phase_r;
      oscRange         <= oscRange_r;
      pumpCurrent      <= pump_r;
    end
  end

  // ********************************
  // Clamp timer
  // ********************************
  // A zero start or length is unsupported; zero simply behaves as 256 here.
  ccp_pkg::ccp_clamp_state_t clampState_r;
  logic [7:0]                clampCnt_r;
  logic                      extSource;

  assign extSource = genCtrl_r[ccp_pkg::CLAMP_SRC_BIT];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      clampState_r <= ccp_pkg::CL_IDLE;
      clampCnt_r   <= 8'h00;
      clampActive  <= 1'b0;
    end
    else if (extSource)
    begin
      clampState_r <= ccp_pkg::CL_IDLE;
      clampActive  <= extClampActive;
    end
    else if (trailEdge)
    begin
      clampState_r <= ccp_pkg::CL_WAIT;
      clampCnt_r   <= clampStart_r;
      clampActive  <= 1'b0;
    end
    else
    begin
      unique case (clampState_r)
        ccp_pkg::CL_IDLE: clampActive <= 1'b0;
        ccp_pkg::CL_WAIT:
        begin
          if (clampCnt_r == 8'h01)
          begin
            clampState_r <= ccp_pkg::CL_ON;
            clampCnt_r   <= clampLength_r;
            clampActive  <= 1'b1;
          end
          else
          begin
            clampCnt_r <= clampCnt_r - 8'h01;
          end
        end
        ccp_pkg::CL_ON:
        begin
          if (clampCnt_r == 8'h01)
          begin
            clampState_r <= ccp_pkg::CL_IDLE;
            clampActive  <= 1'b0;
          end
          else
          begin
            clampCnt_r <= clampCnt_r - 8'h01;
          end
        end
        default:
        begin
          clampState_r <= ccp_pkg::CL_IDLE;
          clampActive  <= 1'b0;
        end
      endcase
    end
  end

  // ********************************
  // Pixel port steering
  // ********************************
  logic       dual;
  logic       parallel;
  logic       pixPhase_r;
  logic       toPortA;
  logic [7:0] pendA_r;
  logic [7:0] portA_r;
  logic [7:0] portB_r;
  logic       portBOe_n_r;
  logic       dataClk_r;

  assign dual     = genCtrl_r[ccp_pkg::DUAL_PORT_BIT];
  assign parallel = genCtrl_r[ccp_pkg::PARALLEL_BIT] & dual;
  assign toPortA  = pixPhase_r ~^ portSwap_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pixPhase_r  <= 1'b0;
      pendA_r     <= 8'h00;
      portA_r     <= 8'h00;
      portB_r     <= 8'h00;
      portBOe_n_r <= 1'b1;
      dataClk_r   <= 1'b0;
    end
    else
    begin
      portBOe_n_r <= ~dual;
      if (leadEdge)
      begin
        pixPhase_r <= 1'b0;
      end
      else if (pixelStrobe)
      begin
        pixPhase_r <= ~pixPhase_r;
        if (!dual)
        begin
          portA_r   <= pixelIn;
          dataClk_r <= ~dataClk_r;
        end
        else if (parallel)
        begin
          if (toPortA)
          begin
            pendA_r   <= pixelIn;
            dataClk_r <= 1'b0;
          end
          else
          begin
            portA_r   <= pendA_r;
            portB_r   <= pixelIn;
            dataClk_r <= 1'b1;
          end
        end
        else if (toPortA)
        begin
          portA_r   <= pixelIn;
          dataClk_r <= 1'b1;
        end
        else
        begin
          portB_r   <= pixelIn;
          dataClk_r <= 1'b0;
        end
      end
    end
  end

  assign link.portAData = portA_r;
  assign link.portBData = portB_r;
  assign link.portBOe_n = portBOe_n_r;
  assign link.dataClk   = dataClk_r;

endmodule // ccp_device

// [hw/ccp_host.sv]
// Purpose: Controller end: Wishbone command registers, device register access, pixel port capture.
// Assumes: Classic Wishbone single cycles with 32-bit data on the same clock as the device.
// Notes:   A new device command while one is in flight is dropped; poll the busy bit first.
`timescale 1ns/10ps
module ccp_host
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Link to the device
  ccp_link_if.host         link
);

  // ********************************
  // Device command issue
  // ********************************
  // Software must keep clamp start and length within 1 to 255 and match clock codes to the pixel rate.
  logic       req;
  logic       regSel_r;
  logic       regWe_r;
  logic [7:0] regAddr_r;
  logic [7:0] regWrData_r;
  logic [7:0] lastRead_r;

  assign req = cyc_i & stb_i & ~ack_o;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      regSel_r    <= 1'b0;
      regWe_r     <= 1'b0;
      regAddr_r   <= 8'h00;
      regWrData_r <= 8'h00;
      lastRead_r  <= 8'h00;
    end
    else if (regSel_r)
    begin
      if (link.regAck)
      begin
        regSel_r <= 1'b0;
        if (!regWe_r)
        begin
          lastRead_r <= link.regRdData;
        end
      end
    end
    else if (req && we_i && adr_i == ccp_pkg::HOST_CMD_OFS && sel_i == 4'hF)
    begin
      regSel_r    <= 1'b1;
      regWe_r     <= dat_i[ccp_pkg::CMD_WRITE_BIT];
      regAddr_r   <= dat_i[ccp_pkg::CMD_ADDR_LSB +: 8];
      regWrData_r <= dat_i[7:0];
    end
  end

  assign link.regSel    = regSel_r;
  assign link.regWe     = regWe_r;
  assign link.regAddr   = regAddr_r;
  assign link.regWrData = regWrData_r;

  // ********************************
  // Pixel capture
  // ********************************
  logic       dataClkPrev_r;
  logic [7:0] capA_r;
  logic [7:0] capB_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dataClkPrev_r <= 1'b0;
      capA_r        <= 8'h00;
      capB_r        <= 8'h00;
    end
    else
    begin
      dataClkPrev_r <= link.dataClk;
      if (link.dataClk & ~dataClkPrev_r)
      begin
        capA_r <= link.portAData;
        if (!link.portBOe_n)
        begin
          capB_r <= link.portBData;
        end
      end
    end
  end

  // ********************************
  // Wishbone answer
  // ********************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= req;
      if (req && !we_i)
      begin
        unique case (adr_i)
          ccp_pkg::HOST_STATUS_OFS: dat_o <= {16'h0000, lastRead_r, 7'h00, regSel_r};
          ccp_pkg::HOST_PIXEL_OFS:  dat_o <= {15'h0000, link.portBOe_n, capB_r, capA_r};
          default:                  dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // ccp_host

// [bench/ccp_assertions.sv]
// Purpose: Link handshake and register read-back checks between the two ends.
// Assumes: One clock; rst_n synchronous, active low.
// Notes:   Shadows follow the writes seen on the link, so a lost write shows on read-back.
`timescale 1ns/10ps
module ccp_assertions
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Link signals
  input wire logic       regSel,
  input wire logic       regWe,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic       regAck,
  input wire logic [7:0] portAData,
  input wire logic [7:0] portBData,
  input wire logic       portBOe_n,
  input wire logic       dataClk
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] start_r;
  logic [7:0] len_r;
  logic [7:0] gen_r;
  logic       swap_r;
  logic [1:0] age_r;
  logic       wrTake;
  logic       rdDone;
  assign wrTake = regSel && regWe && !regAck;
  assign rdDone = regAck && !regWe;
  // The port enable lags the control register, so a few settled cycles are needed.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      age_r <= 2'h0;
    else if (age_r != 2'h3)
      age_r <= age_r + 2'h1;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      start_r <= 8'h80;
      len_r   <= 8'h80;
      gen_r   <= 8'hF4;
      swap_r  <= 1'b0;
    end
    else if (wrTake)
    begin
      if (regAddr == ccp_pkg::CLAMP_START_OFS) start_r <= regWrData;
      if (regAddr == ccp_pkg::CLAMP_LENGTH_OFS) len_r <= regWrData;
      if (regAddr == ccp_pkg::GEN_CTRL_OFS) gen_r <= regWrData;
      if (regAddr == ccp_pkg::OUT_CTRL_OFS) swap_r <= regWrData[4];
    end
  end
  a_ack_after_req: assert property (regSel && !regAck |=> regAck)
    else $error("request not answered in one cycle");
  a_ack_one_pulse: assert property (regAck |=> !regAck)
    else $error("acknowledge longer than one cycle");
  a_sel_release: assert property (regAck |=> !regSel ##1 !regAck)
    else $error("request held after acknowledge");
  a_start_readback: assert property (rdDone && regAddr == ccp_pkg::CLAMP_START_OFS |-> regRdData == start_r)
    else $error("clamp start read-back wrong");
  a_length_readback: assert property (rdDone && regAddr == ccp_pkg::CLAMP_LENGTH_OFS |-> regRdData == len_r)
    else $error("clamp length read-back wrong");
  a_general_readback: assert property (rdDone && regAddr == ccp_pkg::GEN_CTRL_OFS |-> regRdData == {gen_r[7:1], 1'b0})
    else $error("general control read-back wrong");
  a_swap_readback: assert property (rdDone && regAddr == ccp_pkg::OUT_CTRL_OFS |-> regRdData[7:4] == {swap_r, 3'h0})
    else $error("port swap read-back wrong");
  a_revision_field: assert property (rdDone && regAddr == ccp_pkg::OUT_CTRL_OFS |-> regRdData[3:0] == {ccp_pkg::DIE_REVISION, 1'b0})
    else $error("die revision field wrong");
  a_single_port_float: assert property (age_r == 2'h3 && !gen_r[7] && !$past(gen_r[7]) |-> portBOe_n)
    else $error("port B driven in single mode");
  a_dual_port_drive: assert property (age_r == 2'h3 && gen_r[7] && $past(gen_r[7]) |-> !portBOe_n)
    else $error("port B floating in dual mode");
  c_revision_read: cover property (rdDone && regAddr == ccp_pkg::OUT_CTRL_OFS);
  c_start_write: cover property (wrTake && regAddr == ccp_pkg::CLAMP_START_OFS);
  c_dual_data: cover property (dataClk && !portBOe_n && portAData != portBData);
endmodule // ccp_assertions

// [bench/testbench.sv]
// Purpose: Self-checking bench driving the controller over Wishbone and the device pins.
// Assumes: 100 MHz clock; the sync pins have a few cycles of synchroniser latency.
// Notes:   Clamp delays are compared as differences because the pin latency is not fixed.
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module testbench;
  logic        clk, rst_n, cyc, stb, we, ack, lineSync, hold_frequency_in, clampPin, strobe;
  logic        clampActive, pllHold, pllSyncRef, clkExt;
  logic [3:0]  adr, sel;
  logic [31:0] datW, datR;
  logic [7:0]  pixel;
  logic [4:0]  samplePhase;
  logic [1:0]  oscRange;
  logic [2:0]  pumpCurrent;
  int          num_errors, n_checks;
  ccp_link_if link ();
  ccp_device u_ccp_device
  (
    .clk(clk), .rst_n(rst_n), .link(link), .lineSyncIn(lineSync), .coastIn(hold_frequency_in), .clampIn(clampPin),
    .pixelIn(pixel), .pixelStrobe(strobe), .clampActive(clampActive), .pllHold(pllHold),
    .pllSyncRef(pllSyncRef), .clockSourceExt(clkExt), .samplePhase(samplePhase), .oscRange(oscRange),
    .pumpCurrent(pumpCurrent)
  );
  ccp_host u_ccp_host
  (
    .clk(clk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(datW), .dat_o(datR), .ack_o(ack), .link(link)
  );
  ccp_assertions u_ccp_assertions
  (
    .clk(clk), .rst_n(rst_n), .regSel(link.regSel), .regWe(link.regWe), .regAddr(link.regAddr),
    .regWrData(link.regWrData), .regRdData(link.regRdData), .regAck(link.regAck),
    .portAData(link.portAData), .portBData(link.portBData), .portBOe_n(link.portBOe_n), .dataClk(link.dataClk)
  );
  // ******************************
  // Bus and pin helpers
  // ******************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // The request stands until ack is seen; only the watchdog ends a wait that never gets one.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datW <= d;
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    q = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // A second device command is dropped while busy, so status is polled before returning.
  task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [31:0] s;
    int t;
    wb(1'b1, ccp_pkg::HOST_CMD_OFS, {15'h0, w, a, d}, s);
    t = 0;
    do
    begin
      wb(1'b0, ccp_pkg::HOST_STATUS_OFS, 32'h0, s);
      t++;
    end
    while (s[0] !== 1'b0 && t < 20);
    q = s[15:8];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    dev(1'b1, a, d, q);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    dev(1'b0, a, 8'h00, q);
    `CHK("devRead", e, q)
  endtask
  task automatic syncPulse(input logic act);
    @(posedge clk);
    lineSync <= act;
    tick(10);
    lineSync <= !act;
  endtask
  task automatic clampRun(input logic act, input int ln, output int dly);
    int w;
    syncPulse(act);
    dly = 0;
    w = 0;
    while (clampActive !== 1'b1 && dly < 400)
    begin
      @(posedge clk);
      dly++;
    end
    while (clampActive === 1'b1 && w < 300)
    begin
      @(posedge clk);
      w++;
    end
    `CHK("clampWidth", ln, w)
  endtask
  task automatic pix(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk);
    pixel <= a;
    strobe <= 1'b1;
    @(posedge clk);
    pixel <= b;
    @(posedge clk);
    strobe <= 1'b0;
    tick(3);
  endtask
  // ******************************
  // Scenarios
  // ******************************
  task automatic testResets;
    tick(2);
    `CHK("samplePhase", 5'h10, samplePhase)
    `CHK("oscRange", 2'h1, oscRange)
    `CHK("pumpCurrent", 3'h1, pumpCurrent)
    `CHK("clockSource", 1'b0, clkExt)
    rdChk(ccp_pkg::CLAMP_START_OFS, 8'h80);
    rdChk(ccp_pkg::CLAMP_LENGTH_OFS, 8'h80);
    rdChk(ccp_pkg::GEN_CTRL_OFS, 8'hF4);
    rdChk(ccp_pkg::PHASE_OFS, 8'h80);
    rdChk(ccp_pkg::CLK_GEN_OFS, 8'h24);
    rdChk(ccp_pkg::OUT_CTRL_OFS, {4'h0, ccp_pkg::DIE_REVISION, 1'b0});
    rdChk(8'h0F, 8'h00);
  endtask
  task automatic testFields;
    logic [7:0] v;
    for (int i = 0; i < 8; i++)
    begin
      v = {1'b0, i[1:0], i[2:0], 2'b00};
      wr(ccp_pkg::CLK_GEN_OFS, v);
      tick(2);
      `CHK("oscRange", i[1:0], oscRange)
      `CHK("pumpCurrent", i[2:0], pumpCurrent)
      rdChk(ccp_pkg::CLK_GEN_OFS, v);
    end
    wr(ccp_pkg::PHASE_OFS, 8'hFF);
    tick(2);
    `CHK("samplePhase", 5'h1F, samplePhase)
    rdChk(ccp_pkg::PHASE_OFS, 8'hF8);
    wr(ccp_pkg::GEN_CTRL_OFS, 8'hF7);
    tick(2);
    `CHK("clockSource", 1'b1, clkExt)
    rdChk(ccp_pkg::GEN_CTRL_OFS, 8'hF6);
    wr(ccp_pkg::OUT_CTRL_OFS, 8'hFF);
    rdChk(ccp_pkg::OUT_CTRL_OFS, {4'h8, ccp_pkg::DIE_REVISION, 1'b0});
    wr(ccp_pkg::OUT_CTRL_OFS, 8'h00);
    wr(ccp_pkg::GEN_CTRL_OFS, 8'hF4);
  endtask
  task automatic testClamp;
    int d1, d8, dl;
    wr(ccp_pkg::CLAMP_START_OFS, 8'h01);
    wr(ccp_pkg::CLAMP_LENGTH_OFS, 8'h01);
    clampRun(1'b1, 1, d1);
    wr(ccp_pkg::CLAMP_START_OFS, 8'h08);
    wr(ccp_pkg::CLAMP_LENGTH_OFS, 8'h10);
    clampRun(1'b1, 16, d8);
    `CHK("clampStartStep", 7, d8 - d1)
    `CHK("clampStartNear", 1'b1, d1 >= 2 && d1 <= 8)
    @(posedge clk);
    lineSync <= 1'b1;
    wr(ccp_pkg::GEN_CTRL_OFS, 8'hD4);
    // Flipping the polarity makes one false trailing edge, so its clamp pulse must die out first.
    tick(40);
    clampRun(1'b0, 16, dl);
    `CHK("clampLowSync", d8, dl)
  endtask
  task automatic testExtClamp;
    int cnt;
    wr(ccp_pkg::GEN_CTRL_OFS, 8'hFC);
    lineSync <= 1'b0;
    cnt = 0;
    repeat (60)
    begin
      @(posedge clk);
      if (clampActive !== 1'b0) cnt++;
    end
    `CHK("extIgnoresTimer", 0, cnt)
    clampPin <= 1'b1;
    tick(8);
    `CHK("extClampHigh", 1'b1, clampActive)
    clampPin <= 1'b0;
    tick(8);
    `CHK("extClampPass", 1'b0, clampActive)
    wr(ccp_pkg::GEN_CTRL_OFS, 8'hF8);
    tick(8);
    `CHK("extClampLow", 1'b1, clampActive)
    clampPin <= 1'b1;
    tick(8);
    `CHK("extClampLowPass", 1'b0, clampActive)
  endtask
  task automatic testCoast;
    wr(ccp_pkg::GEN_CTRL_OFS, 8'hF4);
    hold_frequency_in <= 1'b1;
    tick(8);
    `CHK("holdHigh", 1'b1, pllHold)
    lineSync <= 1'b1;
    tick(8);
    `CHK("syncGated", 1'b0, pllSyncRef)
    hold_frequency_in <= 1'b0;
    tick(8);
    `CHK("syncPassed", 1'b1, pllSyncRef)
    `CHK("holdFree", 1'b0, pllHold)
    lineSync <= 1'b0;
    wr(ccp_pkg::GEN_CTRL_OFS, 8'hE4);
    tick(8);
    `CHK("holdLowPol", 1'b1, pllHold)
    hold_frequency_in <= 1'b1;
    tick(8);
    `CHK("freeLowPol", 1'b0, pllHold)
  endtask
  task automatic testPorts;
    logic [31:0] s;
    wr(ccp_pkg::GEN_CTRL_OFS, 8'h74);
    pix(8'hAA, 8'h55);
    `CHK("portBFloat", 1'b1, link.portBOe_n)
    `CHK("singlePortA", 8'h55, link.portAData)
    wr(ccp_pkg::GEN_CTRL_OFS, 8'hF4);
    syncPulse(1'b1);
    tick(8);
    pix(8'h11, 8'h22);
    `CHK("dualParallel", 17'h02211, {link.portBOe_n, link.portBData, link.portAData})
    wb(1'b0, ccp_pkg::HOST_PIXEL_OFS, 32'h0, s);
    `CHK("hostLatch", 17'h02211, s[16:0])
    wr(ccp_pkg::OUT_CTRL_OFS, 8'h10);
    syncPulse(1'b1);
    tick(8);
    pix(8'h33, 8'h44);
    `CHK("swapParallel", 16'h1133, {link.portAData, link.portBData})
    wr(ccp_pkg::GEN_CTRL_OFS, 8'hB4);
    syncPulse(1'b1);
    tick(8);
    pix(8'h55, 8'h66);
    `CHK("swapAlternate", 16'h6655, {link.portAData, link.portBData})
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    tick(30000);
    num_errors++;
    conclude();
  end
  initial
  begin
    {rst_n, cyc, stb, we, lineSync, hold_frequency_in, clampPin, strobe} = '0;
    adr = 4'h0;
    sel = 4'hF;
    datW = 32'h0;
    pixel = 8'h00;
    tick(4);
    rst_n <= 1'b1;
    testResets();
    testFields();
    testClamp();
    testExtClamp();
    testCoast();
    testPorts();
    rst_n <= 1'b0;
    tick(4);
    rst_n <= 1'b1;
    testResets();
    conclude();
  end
endmodule // testbench
